// file: core/rgb_led_pkg.sv
// constants and types shared by the two-wire slave and the 32 kHz mode sync
package rgb_led_pkg;
    localparam logic [6:0] SLAVE_ADDR_BASE  = 7'h32;
    localparam logic [7:0] REG_EXEC_CTRL    = 8'h00;
    localparam logic [7:0] REG_CHANNEL_MODE = 8'h01;
    localparam int         CHANNELS         = 3;
    localparam int         FIELD_W          = 2;
    localparam int         RED_POS          = 4;
    localparam int         GREEN_POS        = 2;
    localparam int         BLUE_POS         = 0;
    localparam int         FIELDS_W         = 6;
    localparam logic [5:0] MODE_RESET       = 6'h00;
    localparam logic [5:0] EXEC_RESET       = 6'h00;
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0] LAST_TX_BIT      = 4'h7;

    typedef enum logic [1:0] {
        MODE_DISABLED = 2'h0,
        MODE_LOAD     = 2'h1,
        MODE_RUN      = 2'h2,
        MODE_DIRECT   = 2'h3
    } chan_mode_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef struct packed {
        chan_mode_t mode;
        logic [1:0] exec;
        logic       pc_reset;
        logic       current_off;
        logic       run_enable;
    } chan_ctrl_t;
endpackage

// file: core/mode_sync_32k.sv
// carries the channel mode and execution fields into the 32 kHz domain
`timescale 1ns/1ps
module mode_sync_32k (
    input  logic                            clk_32k,
    input  logic                            rst,
    input  logic                            xfer_tog,
    input  logic [5:0]                      mode_bus,
    input  logic [5:0]                      exec_bus,
    output rgb_led_pkg::chan_ctrl_t [2:0]   chan
);
    import rgb_led_pkg::*;

    logic [2:0] rst_sync;
    logic [2:0] tog_sync;
    logic       rst_32;
    logic       tog_f;
    logic       tog_seen;
    logic [5:0] mode_cur;
    logic [5:0] exec_cur;
    wire        tog_event = tog_f ^ tog_seen;

    // reset only needs to settle, so it is taken from the third stage
    always_ff @(posedge clk_32k)
    begin
        rst_sync <= {rst_sync[1:0], rst};
    end

    assign rst_32 = rst_sync[2];

    always_ff @(posedge clk_32k)
    begin
        if (rst_32)
        begin
            tog_sync <= 3'h0;
            tog_f    <= 1'b0;
            tog_seen <= 1'b0;
        end
        else
        begin
            tog_sync <= {tog_sync[1:0], xfer_tog};
            if (tog_sync[1] == tog_sync[2])
                tog_f <= tog_sync[2];
            tog_seen <= tog_f;
        end
    end

    // buses are stable long before the toggle arrives here
    always_ff @(posedge clk_32k)
    begin
        if (rst_32)
        begin
            mode_cur <= MODE_RESET;
            exec_cur <= EXEC_RESET;
        end
        else if (tog_event)
        begin
            mode_cur <= mode_bus;
            exec_cur <= exec_bus;
        end
    end

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_chan
            wire chan_mode_t m = chan_mode_t'(mode_cur[i*FIELD_W +: FIELD_W]);
            always_ff @(posedge clk_32k)
            begin
                if (rst_32)
                    chan[i] <= '{MODE_DISABLED, 2'h0, 1'b1, 1'b1, 1'b0};
                else
                begin
                    chan[i].mode        <= m;
                    chan[i].exec        <= exec_cur[i*FIELD_W +: FIELD_W];
                    chan[i].pc_reset    <= (m != MODE_RUN);
                    chan[i].current_off <= (m == MODE_DISABLED);
                    chan[i].run_enable  <= (m == MODE_RUN);
                end
            end
        end
    endgenerate
endmodule

// file: core/rgb_i2c_slave.sv
// two-wire serial slave with the channel mode and execution registers
`timescale 1ns/1ps
module rgb_i2c_slave (
    input  logic                            mclk,
    input  logic                            rst,
    input  logic                            clk_32k,
    input  rgb_led_pkg::bus_pins_t          bus_in,
    input  logic [1:0]                      addr_sel,
    output logic                            sda_out,
    output logic                            sda_oe,
    output logic                            bus_busy,
    output rgb_led_pkg::chan_ctrl_t [2:0]   chan
);
    import rgb_led_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK,
        ST_IGNORE
    } state_t;

    typedef enum {
        KIND_ADDR,
        KIND_PTR,
        KIND_DATA
    } byte_kind_t;

    // pin synchronisers: three stages, a change counts once 2 and 3 agree
    logic [3:0] pin_raw;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_f;
    assign pin_raw = {addr_sel, bus_in.scl, bus_in.sda};
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_pin
            always_ff @(posedge mclk)
            begin
                if (rst)
                begin
                    pin_s1[b] <= 1'b1;
                    pin_s2[b] <= 1'b1;
                    pin_s3[b] <= 1'b1;
                    pin_f[b]  <= 1'b1;
                end
                else
                begin
                    pin_s1[b] <= pin_raw[b];
                    pin_s2[b] <= pin_s1[b];
                    pin_s3[b] <= pin_s2[b];
                    if (pin_s2[b] == pin_s3[b])
                        pin_f[b] <= pin_s3[b];
                end
            end
        end
    endgenerate

    wire       sda_f   = pin_f[0];
    wire       scl_f   = pin_f[1];
    wire [1:0] sel_f   = pin_f[3:2];
    logic scl_q;
    logic sda_q;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // bus events on the filtered lines
    wire scl_rise   = scl_f & ~scl_q;
    wire scl_fall   = ~scl_f & scl_q;
    wire start_cond = scl_f & scl_q & sda_q & ~sda_f;
    wire stop_cond  = scl_f & scl_q & ~sda_q & sda_f;

    // protocol state
    state_t     state;
    state_t     next_state;
    byte_kind_t kind;
    byte_kind_t next_kind;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic       rw;
    logic       next_rw;
    logic       drive_low;
    logic       next_drive_low;
    logic       acked;
    logic       next_acked;
    logic       busy;
    logic       next_busy;
    // register file and the toggle that hands it to the 32 kHz side
    logic [5:0] mode_reg;
    logic [5:0] next_mode_reg;
    logic [5:0] exec_reg;
    logic [5:0] next_exec_reg;
    logic       xfer_tog;
    logic       next_xfer_tog;
    // address decode
    wire [6:0] own_addr  = SLAVE_ADDR_BASE + {5'h0, sel_f};
    wire       addr_hit  = (shreg[7:1] == own_addr);
    wire       byte_done = scl_fall && (bit_cnt == BITS_PER_BYTE);
    wire [7:0] ptr_inc   = ptr + 8'h01;
    wire       wr_mode   = (ptr == REG_CHANNEL_MODE);
    wire       wr_exec   = (ptr == REG_EXEC_CTRL);
    // unmapped addresses read as zero and drop writes
    function automatic logic [7:0] read_reg(
        input logic [7:0] a,
        input logic [5:0] m,
        input logic [5:0] e
    );
        logic [7:0] d;
        d = 8'h00;
        if (a == REG_CHANNEL_MODE)
            d = {2'h0, m};
        else if (a == REG_EXEC_CTRL)
            d = {2'h0, e};
        return d;
    endfunction

    wire [7:0] rd_cur  = read_reg(ptr, mode_reg, exec_reg);
    wire [7:0] rd_next = read_reg(ptr_inc, mode_reg, exec_reg);
    always_comb
    begin
        next_state     = state;
        next_kind      = kind;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_ptr       = ptr;
        next_rw        = rw;
        next_drive_low = drive_low;
        next_acked     = acked;
        next_busy      = busy;
        next_mode_reg  = mode_reg;
        next_exec_reg  = exec_reg;
        next_xfer_tog  = xfer_tog;
        if (stop_cond)
        begin
            // a stop anywhere ends the transaction and frees the line
            next_state     = ST_IDLE;
            next_drive_low = 1'b0;
            next_busy      = 1'b0;
        end
        else if (start_cond)
        begin
            // repeated start is simply a fresh address phase
            next_state     = ST_RECV;
            next_kind      = KIND_ADDR;
            next_bit_cnt   = 4'h0;
            next_drive_low = 1'b0;
            next_busy      = 1'b1;
        end
        else
        begin
            unique case (state)
                ST_IDLE, ST_IGNORE:
                begin
                    next_drive_low = 1'b0;
                end
                ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        next_shreg   = {shreg[6:0], sda_f};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (byte_done)
                    begin
                        next_bit_cnt = 4'h0;
                        unique case (kind)
                            KIND_ADDR:
                            begin
                                if (addr_hit)
                                begin
                                    next_state     = ST_ACK;
                                    next_drive_low = 1'b1;
                                    next_rw        = shreg[0];
                                end
                                else
                                    next_state = ST_IGNORE;
                            end
                            KIND_PTR:
                            begin
                                next_ptr       = shreg;
                                next_state     = ST_ACK;
                                next_drive_low = 1'b1;
                            end
                            KIND_DATA:
                            begin
                                if (wr_mode)
                                begin
                                    next_mode_reg = shreg[5:0];
                                    next_xfer_tog = ~xfer_tog;
                                end
                                if (wr_exec)
                                begin
                                    next_exec_reg = shreg[5:0];
                                    next_xfer_tog = ~xfer_tog;
                                end
                                next_state     = ST_ACK;
                                next_drive_low = 1'b1;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    // hold low through the high phase; on the fall release, or for a read drive the first data bit
                    if (scl_fall)
                    begin
                        next_bit_cnt = 4'h0;
                        if (kind == KIND_ADDR && rw)
                        begin
                            next_state     = ST_SEND;
                            next_shreg     = rd_cur;
                            next_drive_low = ~rd_cur[7];
                        end
                        else
                        begin
                            next_state     = ST_RECV;
                            next_drive_low = 1'b0;
                            unique case (kind)
                                KIND_ADDR: next_kind = KIND_PTR;
                                KIND_PTR:  next_kind = KIND_DATA;
                                KIND_DATA: next_ptr  = ptr_inc;
                            endcase
                        end
                    end
                end
                ST_SEND:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt == LAST_TX_BIT)
                        begin
                            next_state     = ST_MACK;
                            next_drive_low = 1'b0;
                        end
                        else
                        begin
                            next_shreg     = {shreg[6:0], 1'b0};
                            next_bit_cnt   = bit_cnt + 4'h1;
                            next_drive_low = ~shreg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                        next_acked = ~sda_f;
                    if (scl_fall)
                    begin
                        next_bit_cnt = 4'h0;
                        if (acked)
                        begin
                            next_ptr       = ptr_inc;
                            next_shreg     = rd_next;
                            next_drive_low = ~rd_next[7];
                            next_state     = ST_SEND;
                        end
                        else
                            next_state = ST_IGNORE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state     <= ST_IDLE;
            kind      <= KIND_ADDR;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            rw        <= 1'b0;
            drive_low <= 1'b0;
            acked     <= 1'b0;
            busy      <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            kind      <= next_kind;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            ptr       <= next_ptr;
            rw        <= next_rw;
            drive_low <= next_drive_low;
            acked     <= next_acked;
            busy      <= next_busy;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_reg <= MODE_RESET;
            exec_reg <= EXEC_RESET;
            xfer_tog <= 1'b0;
        end
        else
        begin
            mode_reg <= next_mode_reg;
            exec_reg <= next_exec_reg;
            xfer_tog <= next_xfer_tog;
        end
    end

    // open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe   = drive_low;
    assign bus_busy = busy;
    // a second write inside the sync window may be missed by the controller
    mode_sync_32k u_mode_sync (
        .clk_32k  (clk_32k),
        .rst      (rst),
        .xfer_tog (xfer_tog),
        .mode_bus (mode_reg),
        .exec_bus (exec_reg),
        .chan     (chan)
    );
endmodule

// file: verification/host_bus_master.sv
// host-side bus master model for the two-wire slave
`timescale 1ns/1ps
module host_bus_master (
    input  logic                   mclk,
    input  logic                   sda_oe,
    output rgb_led_pkg::bus_pins_t bus
);
    import rgb_led_pkg::*;
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;

    // pull-ups: a line is low only while some party pulls it
    assign bus.scl = scl_m;
    assign bus.sda = sda_m & ~sda_oe;

    // ten mclk per phase leaves margin over the slave's input filter
    task automatic half();
        repeat (10) @(posedge mclk);
    endtask

    // also serves as repeated start when the clock is low
    task automatic start();
        sda_m <= 1'b1;
        half();
        scl_m <= 1'b1;
        half();
        sda_m <= 1'b0;
        half();
        scl_m <= 1'b0;
        half();
    endtask

    task automatic stop();
        sda_m <= 1'b0;
        half();
        scl_m <= 1'b1;
        half();
        sda_m <= 1'b1;
        half();
    endtask

    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        half();
        scl_m <= 1'b1;
        half();
        r = bus.sda;
        scl_m <= 1'b0;
        half();
    endtask

    // read: d is ff so the line stays released; m_ack 0 acknowledges
    task automatic xfer(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(m_ack, a);
        ack = ~a;
    endtask
endmodule

// file: verification/rgb_slave_checker.sv
// concurrent checks on the two-wire slave ports and channel outputs
`timescale 1ns/1ps
module rgb_slave_checker (
    input logic                          mclk,
    input logic                          rst,
    input logic                          clk_32k,
    input rgb_led_pkg::bus_pins_t        bus_in,
    input logic [1:0]                    addr_sel,
    input logic                          sda_out,
    input logic                          sda_oe,
    input logic                          bus_busy,
    input rgb_led_pkg::chan_ctrl_t [2:0] chan
);
    import rgb_led_pkg::*;

    chk_open_drain: assert property (@(posedge mclk) disable iff (rst)
        sda_out == 1'b0) else $error("data output not low");

    chk_ack_holds: assert property (@(posedge mclk) disable iff (rst)
        $rose(bus_in.scl) && sda_oe |=> sda_oe [*8])
        else $error("pull-down dropped in clock high");

    // edges of the pull-down while the clock is high would look like start or stop
    chk_oe_scl_low: assert property (@(posedge mclk) disable iff (rst)
        $changed(sda_oe) |-> !bus_in.scl)
        else $error("pull-down moved in clock high");

    chk_busy_start: assert property (@(posedge mclk) disable iff (rst)
        bus_in.scl && $past(bus_in.scl) && $fell(bus_in.sda)
        |-> ##[1:8] bus_busy) else $error("start not seen");

    chk_busy_stop: assert property (@(posedge mclk) disable iff (rst)
        bus_in.scl && $past(bus_in.scl) && $rose(bus_in.sda)
        |-> ##[1:8] !bus_busy) else $error("stop not seen");

    chk_idle_release: assert property (@(posedge mclk) disable iff (rst)
        !bus_busy |-> !sda_oe) else $error("pull-down on idle bus");

    chk_pc_reset: assert property (@(posedge clk_32k) disable iff (rst)
        chan[0].pc_reset == (chan[0].mode != MODE_RUN) &&
        chan[1].pc_reset == (chan[1].mode != MODE_RUN) &&
        chan[2].pc_reset == (chan[2].mode != MODE_RUN))
        else $error("pc reset wrong for mode");

    chk_dark_off: assert property (@(posedge clk_32k) disable iff (rst)
        chan[0].current_off == (chan[0].mode == MODE_DISABLED) &&
        chan[1].current_off == (chan[1].mode == MODE_DISABLED) &&
        chan[2].current_off == (chan[2].mode == MODE_DISABLED))
        else $error("current off wrong for mode");

    cov_ack: cover property (@(posedge mclk) $rose(sda_oe));
    cov_run: cover property (@(posedge clk_32k) chan[2].run_enable);
    cov_stop: cover property (@(posedge mclk) $fell(bus_busy));
endmodule

bind rgb_i2c_slave rgb_slave_checker u_chk (
    .mclk     (mclk),
    .rst      (rst),
    .clk_32k  (clk_32k),
    .bus_in   (bus_in),
    .addr_sel (addr_sel),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .bus_busy (bus_busy),
    .chan     (chan)
);

// file: verification/tb_rgb_driver_i2c_slave_and_mode_reg.sv
// self-checking bench for the two-wire slave and channel mode register
`timescale 1ns/1ps
module tb_rgb_driver_i2c_slave_and_mode_reg;
    import rgb_led_pkg::*;
    logic             mclk = 1'b0;
    logic             clk_32k = 1'b0;
    logic             rst = 1'b1;
    logic [1:0]       addr_sel = 2'h0;
    bus_pins_t        bus_in;
    logic             sda_out;
    logic             sda_oe;
    logic             bus_busy;
    chan_ctrl_t [2:0] chan;
    int               n_mismatch = 0;
    int               checks = 0;
    logic [7:0]       q;
    logic             ack;
    logic [5:0]       modes [4] = '{6'h1b, 6'h24, 6'h39, 6'h06};

    always #12.5 mclk = ~mclk;
    always #3 clk_32k = ~clk_32k;

    rgb_i2c_slave u_dut (
        .mclk     (mclk),
        .rst      (rst),
        .clk_32k  (clk_32k),
        .bus_in   (bus_in),
        .addr_sel (addr_sel),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .bus_busy (bus_busy),
        .chan     (chan)
    );

    host_bus_master u_host (
        .mclk   (mclk),
        .sda_oe (sda_oe),
        .bus    (bus_in)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (bus_busy !== lvl && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        if (bus_busy !== lvl)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: busy wait ran out", $time);
            end_sim();
        end
    endtask

    function automatic logic [6:0] own();
        return SLAVE_ADDR_BASE + {5'h0, addr_sel};
    endfunction

    task automatic send(input logic [7:0] d, input string what);
        u_host.xfer(d, 1'b1, q, ack);
        check({7'h0, ack}, 8'h01, what);
    endtask

    task automatic open_ptr(input logic [7:0] ptr);
        u_host.start();
        wait_busy(1'b1);
        send({own(), 1'b0}, "write address");
        send(ptr, "pointer");
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d0,
                      input logic [7:0] d1, input int n);
        open_ptr(ptr);
        send(d0, "data 0");
        if (n > 1)
            send(d1, "data 1");
        u_host.stop();
        wait_busy(1'b0);
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] e0,
                      input logic [7:0] e1, input int n);
        open_ptr(ptr);
        u_host.start();
        send({own(), 1'b1}, "read address");
        u_host.xfer(8'hff, n == 1, q, ack);
        check(q, e0, "read byte 0");
        if (n > 1)
        begin
            u_host.xfer(8'hff, 1'b1, q, ack);
            check(q, e1, "read byte 1");
        end
        u_host.stop();
        wait_busy(1'b0);
    endtask

    // long enough for the 32 kHz side to capture and register the fields
    task automatic chk_chan(input logic [5:0] m, input logic [5:0] e);
        chan_mode_t c;
        repeat (40) @(posedge mclk);
        for (int i = 0; i < 3; i++)
        begin
            c = chan_mode_t'(m[2*i +: 2]);
            check({6'h0, chan[i].mode}, {6'h0, c}, "mode");
            check({6'h0, chan[i].exec}, {6'h0, e[2*i +: 2]}, "exec");
            check({5'h0, chan[i].pc_reset, chan[i].current_off,
                   chan[i].run_enable}, {5'h0, c != MODE_RUN,
                   c == MODE_DISABLED, c == MODE_RUN}, "flags");
        end
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        check({6'h0, sda_oe, bus_busy}, 8'h00, "idle after reset");
        chk_chan(6'h00, 6'h00);
        $display("test reset done");
        for (int s = 0; s < 4; s++)
        begin
            addr_sel <= s[1:0];
            repeat (6) @(posedge mclk);
            u_host.start();
            wait_busy(1'b1);
            u_host.xfer({own() ^ 7'h01, 1'b0}, 1'b1, q, ack);
            check({7'h0, ack}, 8'h00, "foreign address");
            u_host.xfer(8'h00, 1'b1, q, ack);
            check({7'h0, ack}, 8'h00, "silent after miss");
            u_host.stop();
            wait_busy(1'b0);
            wr(REG_CHANNEL_MODE, {2'h3, modes[s]}, 8'h00, 1);
            chk_chan(modes[s], 6'h00);
            rd(REG_CHANNEL_MODE, {2'h0, modes[s]}, 8'h00, 1);
        end
        $display("test select done");
        wr(REG_EXEC_CTRL, 8'h2d, 8'h0e, 2);
        chk_chan(6'h0e, 6'h2d);
        rd(REG_EXEC_CTRL, 8'h2d, 8'h0e, 2);
        $display("test increment done");
        // half a data byte then stop: nothing may be stored
        open_ptr(REG_CHANNEL_MODE);
        for (int i = 0; i < 4; i++)
            u_host.bit_io(1'b1, ack);
        u_host.stop();
        wait_busy(1'b0);
        rd(REG_CHANNEL_MODE, 8'h0e, 8'h00, 1);
        $display("test abort done");
        end_sim();
    end
endmodule
